// File: rtl/msh_pkg.sv
package msh_pkg;
  // ------------------------------------------------------------------
  // image geometry
  // ------------------------------------------------------------------
  localparam int          IMG_BYTES = 52;
  localparam logic [5:0]  HDR_BYTES = 6'd4;
  localparam logic [5:0]  MAX_DATA  = 6'd56;
  localparam logic [2:0]  CDB_LAST  = 3'd5;
  localparam logic [7:0]  OP_SENSE  = 8'h1A;

  // ------------------------------------------------------------------
  // command block field positions
  // ------------------------------------------------------------------
  localparam int LUN_MSB   = 7;
  localparam int LUN_LSB   = 5;
  localparam int RSV1_BIT  = 4;
  localparam int DBD_BIT   = 3;
  localparam int RSV1_MSB  = 2;
  localparam int PC_MSB    = 7;
  localparam int PC_LSB    = 6;
  localparam int PCODE_MSB = 5;

  // ------------------------------------------------------------------
  // page selectors, offsets in the image and lengths
  // ------------------------------------------------------------------
  localparam logic [5:0] PG_ELEM  = 6'h1D;
  localparam logic [5:0] PG_GEOM  = 6'h1E;
  localparam logic [5:0] PG_CAPS  = 6'h1F;
  localparam logic [5:0] PG_BAUD  = 6'h20;
  localparam logic [5:0] PG_PAR   = 6'h00;
  localparam logic [5:0] PG_ALL   = 6'h3F;
  localparam logic [5:0] OFS_ELEM = 6'd0;
  localparam logic [5:0] OFS_GEOM = 6'd20;
  localparam logic [5:0] OFS_CAPS = 6'd24;
  localparam logic [5:0] OFS_BAUD = 6'd44;
  localparam logic [5:0] OFS_PAR  = 6'd48;
  localparam logic [5:0] LEN_BIG  = 6'd20;
  localparam logic [5:0] LEN_SML  = 6'd4;
  localparam logic [5:0] LEN_ALL  = 6'd52;

  // ------------------------------------------------------------------
  // status and message codes
  // ------------------------------------------------------------------
  localparam logic [7:0] STS_GOOD  = 8'h00;
  localparam logic [7:0] STS_CHECK = 8'h02;
  localparam logic [7:0] STS_BUSY  = 8'h08;
  localparam logic [7:0] STS_RESV  = 8'h18;
  localparam logic [7:0] MSG_DONE  = 8'h00;

  // ------------------------------------------------------------------
  // apb map
  // ------------------------------------------------------------------
  localparam int          APB_AW     = 12;
  localparam logic [11:0] ADDR_CTRL  = 12'h000;
  localparam logic [11:0] ADDR_STAT  = 12'h004;
  localparam logic [11:0] ADDR_UA    = 12'h008;
  localparam int          CTRL_MSGEN = 0;
  localparam int          STAT_SAVED = 8;
  localparam int          STAT_BUSY  = 9;
  localparam logic        CTRL_RST   = 1'b0;

  // ------------------------------------------------------------------
  // default page image and changeable masks
  // ------------------------------------------------------------------
  localparam logic [7:0] DFLT_IMG [0:51] = '{
    8'h9D, 8'h12, 8'h00, 8'h0B, 8'h00, 8'h01, 8'h00, 8'h01, 8'h00, 8'h0A, 8'h00, 8'h00, 8'h00,
    8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 8'h00, 8'h00, 8'h1E, 8'h02, 8'h00, 8'h00, 8'h1F, 8'h12,
    8'h0A, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h20, 8'h02, 8'h00, 8'h00, 8'h00, 8'h02, 8'h00, 8'h00};
  localparam logic [7:0] MASK_IMG [0:51] = '{
    8'h00, 8'h00, 8'hFF, 8'hFF, 8'h00, 8'h00, 8'hFF, 8'hFF, 8'h00, 8'h00, 8'hFF, 8'hFF, 8'h00,
    8'h00, 8'hFF, 8'hFF, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hFF, 8'h00, 8'h00, 8'h00, 8'hFF, 8'h00};
endpackage : msh_pkg

// File: rtl/msh_top.sv
`timescale 1ns/10ps
`default_nettype none
module msh_top (
  input  wire logic                      ref_clk,
  input  wire logic                      sys_rst,
  input  wire logic [msh_pkg::APB_AW-1:0] paddr,
  input  wire logic                      psel,
  input  wire logic                      penable,
  input  wire logic                      pwrite,
  input  wire logic [31:0]               pwdata,
  output logic      [31:0]               prdata,
  output logic                           pready,
  output logic                           pslverr,
  input  wire logic                      cdb_valid,
  input  wire logic [7:0]                cdb_byte,
  input  wire logic [2:0]                init_id,
  input  wire logic                      other_busy,
  input  wire logic                      abort_motion,
  input  wire logic                      reserved_other,
  input  wire logic                      msg_error,
  input  wire logic                      cdb_parity_err,
  input  wire logic                      bus_reset_evt,
  input  wire logic                      dout_valid,
  input  wire logic [5:0]                dout_idx,
  input  wire logic [7:0]                dout_byte,
  input  wire logic                      sel_end,
  input  wire logic                      sel_save,
  input  wire logic                      sel_invalid,
  input  wire logic                      sel_parity,
  input  wire logic                      phase_ready,
  output logic                           din_valid,
  output logic      [7:0]                din_byte,
  output logic                           status_valid,
  output logic      [7:0]                status_byte,
  output logic                           msg_valid,
  output logic      [7:0]                msg_byte,
  output logic                           bus_free
);
  import msh_pkg::*;

  typedef enum logic [2:0] {ST_IDLE, ST_DATA, ST_STATUS, ST_MSG, ST_FREE} msh_state_t;

  // ------------------------------------------------------------------
  // storage
  // ------------------------------------------------------------------
  msh_state_t  state_r;
  logic [7:0]  cdb_r [0:5];
  logic [2:0]  cnt_r;
  logic [7:0]  cur_r [0:IMG_BYTES-1];
  logic [7:0]  sav_r [0:IMG_BYTES-1];
  logic [7:0]  stg_r [0:IMG_BYTES-1];
  logic [7:0]  mrg   [0:IMG_BYTES-1];
  logic        saved_valid_r;
  logic        msg_en_r;
  logic [7:0]  ua_r;
  logic [7:0]  ua_nxt;
  logic [1:0]  pc_r;
  logic [5:0]  ofs_r;
  logic [5:0]  total_r;
  logic [5:0]  xfer_r;
  logic [5:0]  ptr_r;
  logic [7:0]  sts_r;
  logic        din_valid_r;
  logic [7:0]  din_byte_r;
  logic        status_valid_r;
  logic        msg_valid_r;
  logic        bus_free_r;
  logic        pready_r;
  logic        pslverr_r;
  logic [31:0] prdata_r;

  // ------------------------------------------------------------------
  // decode
  // ------------------------------------------------------------------
  function automatic logic [12:0] page_info(input logic [5:0] code);
    case (code)
      PG_ELEM: page_info = {1'b1, OFS_ELEM, LEN_BIG};
      PG_GEOM: page_info = {1'b1, OFS_GEOM, LEN_SML};
      PG_CAPS: page_info = {1'b1, OFS_CAPS, LEN_BIG};
      PG_BAUD: page_info = {1'b1, OFS_BAUD, LEN_SML};
      PG_PAR:  page_info = {1'b1, OFS_PAR, LEN_SML};
      PG_ALL:  page_info = {1'b1, OFS_ELEM, LEN_ALL};
      default: page_info = 13'h0000;
    endcase
  endfunction : page_info

  function automatic logic [7:0] pick_status(input logic busy, input logic resv,
                                             input logic chk);
    if (busy) begin
      pick_status = STS_BUSY;
    end else if (resv) begin
      pick_status = STS_RESV;
    end else if (chk) begin
      pick_status = STS_CHECK;
    end else begin
      pick_status = STS_GOOD;
    end
  endfunction : pick_status

  // page offsets are even, so bytes 0 and 1 of a page share one even base
  function automatic logic page_head(input logic [5:0] idx);
    page_head = ({idx[5:1], 1'b0} == OFS_ELEM) || ({idx[5:1], 1'b0} == OFS_GEOM) ||
                ({idx[5:1], 1'b0} == OFS_CAPS) || ({idx[5:1], 1'b0} == OFS_BAUD) ||
                ({idx[5:1], 1'b0} == OFS_PAR);
  endfunction : page_head

  logic [1:0]  pc;
  logic [5:0]  pcode;
  logic [12:0] pinfo;
  logic [5:0]  total;
  logic [5:0]  xfer;
  logic        busy_c;
  logic        ua_me;
  logic        cdb_chk;
  logic        sel_chk;
  logic [7:0]  sense_sts;
  logic [7:0]  sel_sts;
  logic        cdb_last;
  logic        cdb_done;
  logic        sel_go;
  logic        sel_commit;
  logic        changed;
  logic        din_adv;
  logic        din_end;
  logic        status_go;
  logic [5:0]  img_idx;
  logic [7:0]  src_byte;

  always_comb begin
    pc        = cdb_r[2][PC_MSB:PC_LSB];
    pcode     = cdb_r[2][PCODE_MSB:0];
    pinfo     = page_info(pcode);
    total     = HDR_BYTES + pinfo[5:0];
    xfer      = ({2'b00, total} > cdb_r[4]) ? cdb_r[4][5:0] : total;
    busy_c    = other_busy | abort_motion;
    ua_me     = ua_r[init_id];
    cdb_chk   = (msg_en_r ? msg_error : cdb_parity_err)
              | (cdb_r[1][LUN_MSB:LUN_LSB] != 3'd0) | cdb_r[1][RSV1_BIT]
              | (|cdb_r[1][RSV1_MSB:0]) | (|cdb_r[3]) | ~pinfo[12]
              | ~cdb_r[1][DBD_BIT]
              | ua_me;
    sel_chk   = (msg_en_r ? msg_error : sel_parity) | sel_invalid | ua_me;
    sense_sts = pick_status(busy_c, reserved_other, cdb_chk);
    sel_sts   = pick_status(busy_c, reserved_other, sel_chk);
    cdb_last  = (state_r == ST_IDLE) && cdb_valid && (cnt_r == CDB_LAST);
    cdb_done  = cdb_last && (cdb_r[0] == OP_SENSE);
    // with messaging on, a parity hit is retried by the phase logic, no status yet
    sel_go    = (state_r == ST_IDLE) && sel_end && !(msg_en_r && sel_parity) && !cdb_last;
    sel_commit = sel_go && (sel_sts == STS_GOOD);
    din_adv   = (state_r == ST_DATA) && (!din_valid_r || phase_ready);
    din_end   = din_adv && (ptr_r == xfer_r);
    status_go = (cdb_done && !((sense_sts == STS_GOOD) && (xfer != 6'd0))) || sel_go || din_end;
  end

  always_comb begin
    changed = 1'b0;
    for (int i = 0; i < IMG_BYTES; i++) begin
      mrg[i]  = (cur_r[i] & ~MASK_IMG[i]) | (stg_r[i] & MASK_IMG[i]);
      changed = changed | (mrg[i] != cur_r[i]);
    end
  end

  always_comb begin
    img_idx  = ofs_r + ptr_r - HDR_BYTES;
    src_byte = 8'h00;
    if (ptr_r == 6'd0) begin
      src_byte = {2'b00, total_r - 6'd1};
    end else if (ptr_r >= HDR_BYTES) begin
      case (pc_r)
        2'd0:    src_byte = cur_r[img_idx];
        2'd1:    src_byte = page_head(img_idx) ? DFLT_IMG[img_idx] : MASK_IMG[img_idx];
        2'd2:    src_byte = DFLT_IMG[img_idx];
        default: src_byte = saved_valid_r ? sav_r[img_idx] : DFLT_IMG[img_idx];
      endcase
    end
  end

  // ------------------------------------------------------------------
  // command block capture
  // ------------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      cnt_r <= 3'd0;
      for (int i = 0; i < 6; i++) begin
        cdb_r[i] <= 8'h00;
      end
    end else if ((state_r == ST_IDLE) && cdb_valid) begin
      cdb_r[cnt_r] <= cdb_byte;
      cnt_r        <= cdb_last ? 3'd0 : cnt_r + 3'd1;
    end
  end

  // ------------------------------------------------------------------
  // page copies
  // ------------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      saved_valid_r <= 1'b0;
      for (int i = 0; i < IMG_BYTES; i++) begin
        cur_r[i] <= DFLT_IMG[i];
        sav_r[i] <= DFLT_IMG[i];
        stg_r[i] <= DFLT_IMG[i];
      end
    end else begin
      if (dout_valid && (dout_idx < LEN_ALL)) begin
        stg_r[dout_idx] <= dout_byte;
      end
      if (sel_commit) begin
        for (int i = 0; i < IMG_BYTES; i++) begin
          cur_r[i] <= mrg[i];
          if (sel_save) begin
            sav_r[i] <= mrg[i];
          end
        end
        if (sel_save) begin
          saved_valid_r <= 1'b1;
        end
      end else if (bus_reset_evt) begin
        for (int i = 0; i < IMG_BYTES; i++) begin
          cur_r[i] <= saved_valid_r ? sav_r[i] : DFLT_IMG[i];
        end
      end
    end
  end

  // ------------------------------------------------------------------
  // unit attention: hardware set beats software clear
  // ------------------------------------------------------------------
  always_comb begin
    ua_nxt = ua_r;
    if (pready_r && psel && penable && pwrite && (paddr == ADDR_UA)) begin
      ua_nxt = ua_nxt & ~pwdata[7:0];
    end
    if ((cdb_done && (sense_sts == STS_CHECK) && ua_me) ||
        (sel_go && (sel_sts == STS_CHECK) && ua_me)) begin
      ua_nxt[init_id] = 1'b0;
    end
    if (sel_commit && changed) begin
      ua_nxt = ua_nxt | ~(8'h01 << init_id);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      ua_r <= 8'h00;
    end else begin
      ua_r <= ua_nxt;
    end
  end

  // ------------------------------------------------------------------
  // phase sequencing
  // ------------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      state_r <= ST_IDLE;
      pc_r    <= 2'd0;
      ofs_r   <= 6'd0;
      total_r <= 6'd0;
      xfer_r  <= 6'd0;
      sts_r   <= STS_GOOD;
    end else begin
      case (state_r)
        ST_IDLE: begin
          if (cdb_done) begin
            pc_r    <= pc;
            ofs_r   <= pinfo[11:6];
            total_r <= total;
            xfer_r  <= xfer;
            sts_r   <= sense_sts;
            state_r <= status_go ? ST_STATUS : ST_DATA;
          end else if (sel_go) begin
            sts_r   <= sel_sts;
            state_r <= ST_STATUS;
          end
        end
        ST_DATA: begin
          if (din_end) begin
            state_r <= ST_STATUS;
          end
        end
        ST_STATUS: begin
          if (phase_ready) begin
            state_r <= ST_MSG;
          end
        end
        ST_MSG: begin
          if (phase_ready) begin
            state_r <= ST_FREE;
          end
        end
        ST_FREE: state_r <= ST_IDLE;
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      ptr_r       <= 6'd0;
      din_valid_r <= 1'b0;
      din_byte_r  <= 8'h00;
    end else if (cdb_done) begin
      ptr_r       <= 6'd0;
      din_valid_r <= 1'b0;
    end else if (din_adv) begin
      if (ptr_r < xfer_r) begin
        din_byte_r  <= src_byte;
        din_valid_r <= 1'b1;
        ptr_r       <= ptr_r + 6'd1;
      end else begin
        din_valid_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      status_valid_r <= 1'b0;
      msg_valid_r    <= 1'b0;
      bus_free_r     <= 1'b0;
    end else begin
      bus_free_r <= 1'b0;
      if (status_go) begin
        status_valid_r <= 1'b1;
      end else if ((state_r == ST_STATUS) && phase_ready) begin
        status_valid_r <= 1'b0;
        msg_valid_r    <= 1'b1;
      end else if ((state_r == ST_MSG) && phase_ready) begin
        msg_valid_r <= 1'b0;
        bus_free_r  <= 1'b1;
      end
    end
  end

  // ------------------------------------------------------------------
  // apb slave, one wait state so read data comes from a flop
  // ------------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r  <= 32'h0000_0000;
      msg_en_r  <= CTRL_RST;
    end else begin
      pready_r  <= psel && penable && !pready_r;
      pslverr_r <= 1'b0;
      prdata_r  <= 32'h0000_0000;
      if (psel && penable && !pready_r) begin
        case (paddr)
          ADDR_CTRL: prdata_r[CTRL_MSGEN] <= msg_en_r;
          ADDR_STAT: prdata_r <= {22'h00_0000, state_r != ST_IDLE, saved_valid_r, sts_r};
          ADDR_UA:   prdata_r <= {24'h00_0000, ua_r};
          default:   pslverr_r <= 1'b1;
        endcase
      end
      if (pready_r && psel && penable && pwrite && (paddr == ADDR_CTRL)) begin
        msg_en_r <= pwdata[CTRL_MSGEN];
      end
    end
  end

  assign prdata       = prdata_r;
  assign pready       = pready_r;
  assign pslverr      = pslverr_r;
  assign din_valid    = din_valid_r;
  assign din_byte     = din_byte_r;
  assign status_valid = status_valid_r;
  assign status_byte  = sts_r;
  assign msg_valid    = msg_valid_r;
  assign msg_byte     = MSG_DONE;
  assign bus_free     = bus_free_r;

  // ------------------------------------------------------------------
  // checks
  // ------------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  AST_SEL_GOOD: assert property (sel_go && !busy_c && !reserved_other && !sel_chk |=>
    (sts_r == STS_GOOD) && (cur_r[2] == $past(mrg[2]))) else $error("select good without copy");
  AST_BUSY: assert property (cdb_done && busy_c |=> sts_r == STS_BUSY)
    else $error("busy not returned");
  AST_RESV: assert property (cdb_done && !busy_c && reserved_other |=>
    sts_r == STS_RESV) else $error("reservation conflict not returned");
  AST_MSGERR: assert property (cdb_done && !busy_c && !reserved_other &&
    (msg_en_r ? msg_error : cdb_parity_err) |=> sts_r == STS_CHECK) else $error("msg check missed");
  AST_LUN: assert property (cdb_done && !busy_c && !reserved_other &&
    (cdb_r[1][LUN_MSB:LUN_LSB] != 3'd0) |=> sts_r == STS_CHECK) else $error("bad lun passed");
  AST_UA: assert property (cdb_done && !busy_c && !reserved_other && ua_me |=>
    (sts_r == STS_CHECK) && !ua_r[$past(init_id)]) else $error("unit attention missed");
  AST_SELPAR: assert property (sel_go && !busy_c && !reserved_other && sel_parity &&
    !msg_en_r |=> sts_r == STS_CHECK) else $error("select parity passed");
  AST_LEN: assert property (din_valid_r |-> (ptr_r <= xfer_r) && (xfer_r <= MAX_DATA))
    else $error("data length exceeded");
  AST_END: assert property (din_end |=> status_valid_r && !din_valid_r &&
    ($past(ptr_r) == xfer_r)) else $error("data phase ended wrong");
  AST_HDR: assert property (din_valid_r && (ptr_r == 6'd1) |->
    din_byte_r == {2'b00, total_r - 6'd1}) else $error("header count wrong");
  AST_MSG: assert property ((state_r == ST_STATUS) && phase_ready |=>
    msg_valid_r && !status_valid_r ##1 (msg_valid_r || bus_free_r)) else $error("no completion");
  AST_UASET: assert property (sel_commit && changed |=>
    &(ua_r | (8'h01 << $past(init_id)))) else $error("unit attention not set");

  COV_ALL: cover property (cdb_done && (pcode == PG_ALL) && (xfer == MAX_DATA));
  COV_BUSY: cover property (cdb_done && busy_c);
  COV_COMMIT: cover property (sel_commit && changed && sel_save);
  COV_FREE: cover property (bus_free_r);
endmodule : msh_top
`default_nettype wire

// File: sim/msh_init_model.sv
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------
// initiator side: takes data-in, status and message bytes
// ----------------------------------------
module msh_init_model (
  input  wire logic       ref_clk,
  input  wire logic       sys_rst,
  input  wire logic       clr,
  input  wire logic       slow,
  input  wire logic       din_valid,
  input  wire logic [7:0] din_byte,
  input  wire logic       status_valid,
  input  wire logic [7:0] status_byte,
  input  wire logic       msg_valid,
  input  wire logic [7:0] msg_byte,
  input  wire logic       bus_free,
  output logic            phase_ready
);
  logic [7:0] got [0:63];
  logic [7:0] sts, msg;
  logic       done;
  int         n;
  // slow mode drops phase_ready on every other cycle, as a busy host would
  always_ff @(posedge ref_clk) begin
    if (sys_rst || clr) begin
      phase_ready <= 1'b0;
      n <= 0;
      done <= 1'b0;
      sts <= 8'hFF;
      msg <= 8'hFF;
    end else begin
      phase_ready <= slow ? ~phase_ready : 1'b1;
      if (din_valid && phase_ready) begin
        got[n] <= din_byte;
        n <= n + 1;
      end
      if (status_valid && phase_ready) sts <= status_byte;
      if (msg_valid && phase_ready) msg <= msg_byte;
      if (bus_free) done <= 1'b1;
    end
  end
endmodule : msh_init_model
`default_nettype wire

// File: sim/tb.sv
`timescale 1ns/10ps
`default_nettype none
module tb;
  import msh_pkg::*;
  logic ref_clk = 1'b0, sys_rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic cdb_valid = 1'b0, bus_reset_evt = 1'b0, dout_valid = 1'b0, sel_end = 1'b0;
  logic clr = 1'b0, slow = 1'b0, perr, pready, pslverr, phase_ready;
  logic other_busy, abort_motion, reserved_other, msg_error, cdb_parity_err;
  logic sel_save, sel_invalid, sel_parity, din_valid, status_valid, msg_valid, bus_free;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, q;
  logic [7:0] cdb_byte = 8'h00, dout_byte = 8'h00, din_byte, status_byte, msg_byte;
  logic [7:0] e [0:55];
  logic [7:0] cur [0:51];
  logic [5:0] dout_idx = 6'h00;
  logic [5:0] ofs [0:5] = '{OFS_ELEM, OFS_GEOM, OFS_CAPS, OFS_BAUD, OFS_PAR, OFS_ELEM};
  logic [5:0] lens [0:5] = '{LEN_BIG, LEN_SML, LEN_BIG, LEN_SML, LEN_SML, LEN_ALL};
  logic [5:0] codes [0:5] = '{PG_ELEM, PG_GEOM, PG_CAPS, PG_BAUD, PG_PAR, PG_ALL};
  logic [2:0] init_id = 3'h0, sf = 3'h0;
  logic [4:0] fl = 5'h00;
  int mismatches = 0, compares = 0;
  assign {other_busy, abort_motion, reserved_other, msg_error, cdb_parity_err} = fl;
  assign {sel_save, sel_invalid, sel_parity} = sf;
  always #50 ref_clk = ~ref_clk;
  msh_top u_dut (.ref_clk, .sys_rst, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready,
    .pslverr, .cdb_valid, .cdb_byte, .init_id, .other_busy, .abort_motion, .reserved_other,
    .msg_error, .cdb_parity_err, .bus_reset_evt, .dout_valid, .dout_idx, .dout_byte, .sel_end,
    .sel_save, .sel_invalid, .sel_parity, .phase_ready, .din_valid, .din_byte, .status_valid,
    .status_byte, .msg_valid, .msg_byte, .bus_free);
  msh_init_model u_init (.ref_clk, .sys_rst, .clr, .slow, .din_valid, .din_byte, .status_valid,
    .status_byte, .msg_valid, .msg_byte, .bus_free, .phase_ready);
  // ----------------------------------------
  // access tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic summarize;
    $display("mismatches=%0d compares=%0d", mismatches, compares);
    if (mismatches == 0 && compares > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : summarize
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    @(posedge ref_clk);
    {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
    @(posedge ref_clk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge ref_clk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    if (k == 50) begin
      mismatches++;
      summarize();
    end
    q = prdata;
    perr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic fin(input logic [7:0] sx, input int nx);
    int k;
    k = 0;
    while (u_init.done !== 1'b1 && k < 400) begin
      @(posedge ref_clk);
      k++;
    end
    if (k == 400) begin
      mismatches++;
      summarize();
    end
    chk(u_init.sts, sx);
    chk(u_init.msg, MSG_DONE);
    chk(u_init.n, nx);
    for (k = 0; k < nx; k++) chk(u_init.got[k], e[k]);
  endtask : fin
  task automatic cmd(input logic [7:0] b1, b2, b3, b4, input logic [4:0] f,
                     input logic [7:0] sx, input int nx);
    logic [7:0] cb [0:5];
    cb = '{OP_SENSE, b1, b2, b3, b4, 8'h00};
    @(posedge ref_clk);
    clr <= 1'b1;
    fl <= f;
    for (int k = 0; k < 6; k++) begin
      @(posedge ref_clk);
      clr <= 1'b0;
      cdb_valid <= 1'b1;
      cdb_byte <= cb[k];
    end
    @(posedge ref_clk);
    cdb_valid <= 1'b0;
    fin(sx, nx);
    fl <= 5'h00;
  endtask : cmd
  task automatic sense(input int t, input logic [1:0] pc, input logic [7:0] al,
                       input logic [4:0] f, input logic [7:0] sx);
    int n;
    n = int'(lens[t]) + 4;
    e[0] = 8'(n - 1);
    {e[1], e[2], e[3]} = 24'h0;
    for (int k = 0; k < lens[t]; k++)
      e[k+4] = pc == 2'd1 ? (k < 2 ? DFLT_IMG[ofs[t]+k] : MASK_IMG[ofs[t]+k])
             : pc == 2'd2 ? DFLT_IMG[ofs[t]+k] : cur[ofs[t]+k];
    cmd(8'h08, {pc, codes[t]}, 8'h00, al, f, sx, sx != STS_GOOD ? 0 : n < al ? n : al);
  endtask : sense
  task automatic sel(input logic [7:0] d, input logic [2:0] s, input logic [7:0] sx);
    for (int i = 0; i < 52; i++) begin
      @(posedge ref_clk);
      clr <= 1'b1;
      {dout_valid, dout_idx} <= {1'b1, 6'(i)};
      dout_byte <= i == 3 ? d : i == 4 ? 8'h55 : cur[i];
    end
    @(posedge ref_clk);
    {clr, dout_valid, sel_end, sf} <= {3'b001, s};
    @(posedge ref_clk);
    sel_end <= 1'b0;
    fin(sx, 0);
  endtask : sel
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    for (int i = 0; i < 52; i++) cur[i] = DFLT_IMG[i];
    repeat (4) @(posedge ref_clk);
    sys_rst <= 1'b0;
    apb(1'b0, ADDR_STAT, 32'h0);
    chk(q, 32'h0);
    apb(1'b0, 12'h00C, 32'h0);
    chk(perr, 1'b1);
    for (int t = 0; t < 6; t++) sense(t, 2'd2, 8'hFF, 5'h00, STS_GOOD);
    sense(0, 2'd1, 8'hFF, 5'h00, STS_GOOD);
    slow <= 1'b1;
    sense(5, 2'd0, 8'h0A, 5'h00, STS_GOOD);
    slow <= 1'b0;
    sense(5, 2'd0, 8'hFF, 5'h00, STS_GOOD);
    cmd(8'h00, 8'h9D, 8'h00, 8'hFF, 5'h00, STS_CHECK, 0);
    cmd(8'h28, 8'h9D, 8'h00, 8'hFF, 5'h00, STS_CHECK, 0);
    cmd(8'h18, 8'h9D, 8'h00, 8'hFF, 5'h00, STS_CHECK, 0);
    cmd(8'h08, 8'h9D, 8'h01, 8'hFF, 5'h00, STS_CHECK, 0);
    cmd(8'h08, 8'h85, 8'h00, 8'hFF, 5'h00, STS_CHECK, 0);
    sense(0, 2'd2, 8'hFF, 5'h10, STS_BUSY);
    sense(0, 2'd2, 8'hFF, 5'h08, STS_BUSY);
    sense(0, 2'd2, 8'hFF, 5'h04, STS_RESV);
    sense(0, 2'd2, 8'hFF, 5'h14, STS_BUSY);
    sense(0, 2'd2, 8'hFF, 5'h01, STS_CHECK);
    sense(0, 2'd2, 8'hFF, 5'h02, STS_GOOD);
    apb(1'b1, ADDR_CTRL, 32'h1);
    sense(0, 2'd2, 8'hFF, 5'h02, STS_CHECK);
    apb(1'b1, ADDR_CTRL, 32'h0);
    sel(8'h22, 3'b100, STS_GOOD);
    cur[3] = 8'h22;
    apb(1'b0, ADDR_UA, 32'h0);
    chk(q, 32'hFE);
    apb(1'b0, ADDR_STAT, 32'h0);
    chk(q[9:0], 10'h100);
    sense(0, 2'd0, 8'hFF, 5'h00, STS_GOOD);
    sense(0, 2'd3, 8'hFF, 5'h00, STS_GOOD);
    init_id <= 3'h1;
    sense(0, 2'd0, 8'hFF, 5'h00, STS_CHECK);
    apb(1'b1, ADDR_UA, 32'hFC);
    apb(1'b0, ADDR_UA, 32'h0);
    chk(q, 32'h0);
    sel(8'h33, 3'b010, STS_CHECK);
    sel(8'h33, 3'b001, STS_CHECK);
    @(posedge ref_clk);
    bus_reset_evt <= 1'b1;
    @(posedge ref_clk);
    bus_reset_evt <= 1'b0;
    sense(0, 2'd0, 8'hFF, 5'h00, STS_GOOD);
    summarize();
  end
endmodule : tb
`default_nettype wire
